// File: rtl/bfpd_boot_decode.v
`timescale 1ns/1ps
module bfpd_boot_decode
#(
	parameter IS_256K = 0
)
(
	input wire [1:0] boot_size_select,
	output reg [16:0] boot_start,
	output reg [16:0] app_end,
	output reg [13:0] boot_words
);
`include "bfpd_map.vh"
	always @*
	begin
		case (boot_size_select)
			2'h3:
			begin
				boot_start = IS_256K ? `BFPD_BOOT_256K_11 : `BFPD_BOOT_128K_11;
				boot_words = 14'h0200;
			end
			2'h2:
			begin
				boot_start = IS_256K ? `BFPD_BOOT_256K_10 : `BFPD_BOOT_128K_10;
				boot_words = 14'h0400;
			end
			2'h1:
			begin
				boot_start = IS_256K ? `BFPD_BOOT_256K_01 : `BFPD_BOOT_128K_01;
				boot_words = 14'h0800;
			end
			default:
			begin
				boot_start = IS_256K ? `BFPD_BOOT_256K_00 : `BFPD_BOOT_128K_00;
				boot_words = 14'h1000;
			end
		endcase
		app_end = boot_start - 17'h00001;
	end
endmodule

// File: rtl/bfpd_map.vh
`ifndef BFPD_MAP_VH
`define BFPD_MAP_VH

// ----------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------
`define BFPD_OFF_CTRL 8'h00
`define BFPD_OFF_PTR 8'h04
`define BFPD_OFF_EXT 8'h08
`define BFPD_OFF_STAT 8'h0C
`define BFPD_OFF_DECODE 8'h10
`define BFPD_OFF_BOOT 8'h14
`define BFPD_OFF_OPTIME 8'h18
`define BFPD_OFF_APPEND 8'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define BFPD_CTRL_FILL 0
`define BFPD_CTRL_ERASE 1
`define BFPD_CTRL_WRITE 2
`define BFPD_CTRL_REEN 3

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define BFPD_STAT_BUSY 0
`define BFPD_STAT_SECT_BUSY 1
`define BFPD_STAT_STALL 2
`define BFPD_STAT_IN_HALT 3
`define BFPD_STAT_BYTE_SEL 4

// ----------------------------------------
// Geometry and timing
// ----------------------------------------
`define BFPD_PAGE_WORDS 128
`define BFPD_WORD_BITS 7
`define BFPD_HALT_START_128K 17'h0F000
`define BFPD_HALT_START_256K 17'h1F000
`define BFPD_BOOT_128K_11 17'h0FE00
`define BFPD_BOOT_128K_10 17'h0FC00
`define BFPD_BOOT_128K_01 17'h0F800
`define BFPD_BOOT_128K_00 17'h0F000
`define BFPD_BOOT_256K_11 17'h1FE00
`define BFPD_BOOT_256K_10 17'h1FC00
`define BFPD_BOOT_256K_01 17'h1F800
`define BFPD_BOOT_256K_00 17'h1F000
`define BFPD_OP_CYCLES_DEF 16'h0010

`endif

// File: rtl/bfpd_top.v
`timescale 1ns/1ps
// Notes on behaviour
// - 128K: below 0xF000 readable, above halts
// - 256K: below 0x1F000 readable, above halts
// - 128-word pages, word from pointer bits 7:1
// - 128K page index from pointer 16:8
// - 256K page index from pointer 17:8
// - Byte select ignored for stores, used for reads
// - Page index targets erase and write
// - Word index picks buffer fill location
// - 128K boot size fuses pick start address
// - 256K boot start; application ends below it
// - Pointer top bit one above counter top
// - Readable section busy blocks its reads
// - Halt section operation stalls the core
`include "bfpd_map.vh"
module bfpd_top
#(
	parameter IS_256K = 0,
	parameter [15:0] OP_CYCLES = `BFPD_OP_CYCLES_DEF
)
(
	input wire sys_clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [1:0] boot_size_select,
	input wire load_program_read,
	output wire section_read_block,
	output wire core_stall,
	output reg [9:0] op_page_q,
	output reg [6:0] fill_word_q,
	output reg fill_strobe_q,
	output reg read_byte_high_q
);

	// ----------------------------------------
	// Geometry
	// ----------------------------------------
	// counter top bit 15 or 16, pointer top one above
	localparam COUNTER_TOP = IS_256K ? 16 : 15;
	localparam POINTER_TOP = COUNTER_TOP + 1;
	localparam EXT_BITS = IS_256K ? 2 : 1;
	localparam PAGE_BITS = COUNTER_TOP - `BFPD_WORD_BITS + 1;
	// Zero count would never end; run one cycle instead
	localparam [15:0] OP_LOAD = (OP_CYCLES == 16'h0000) ? 16'h0001 : OP_CYCLES;

	localparam ST_IDLE = 2'h0;
	localparam ST_ERASE = 2'h1;
	localparam ST_WRITE = 2'h2;

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg [15:0] pointer_q;
	reg [1:0] page_extension_register;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [15:0] count_q;
	reg section_busy_flag;
	reg halt_op_q;
	reg [31:0] read_data_d;

	// ----------------------------------------
	// Decode nets
	// ----------------------------------------
	wire [17:0] full_ptr;
	wire [16:0] word_addr;
	wire [PAGE_BITS-1:0] page_index;
	wire [9:0] page_index_wide;
	wire [6:0] word_index;
	wire pointer_byte_select;
	wire in_halt_section;
	wire [16:0] boot_start;
	wire [16:0] app_end;
	wire [13:0] boot_words;

	// ----------------------------------------
	// Bus nets
	// ----------------------------------------
	wire wr_acc;
	wire rd_acc;
	wire ctrl_wr;
	wire ptr_wr;
	wire ext_wr;
	wire [1:0] ext_d;
	wire cmd_fill;
	wire cmd_erase;
	wire cmd_write;
	wire cmd_reen;
	wire start_op;
	wire start_rww;
	wire clear_busy;
	wire busy;
	wire [31:0] stat_word;
	wire [31:0] decode_word;
	wire [31:0] boot_word;
	wire [31:0] optime_word;
	wire [31:0] app_end_word;

	// ----------------------------------------
	// Pointer decoding
	// ----------------------------------------
	// Upper pointer bits live in the extension register
	assign full_ptr = {page_extension_register, pointer_q};
	assign pointer_byte_select = full_ptr[0];
	assign word_index = full_ptr[7:1];
	assign page_index = full_ptr[POINTER_TOP:8];
	// Page index widened to ten bits for either size
	assign page_index_wide = IS_256K ? full_ptr[17:8] :
		{1'b0, full_ptr[16:8]};
	// Extension bit 1 always reads zero on the smaller part
	assign word_addr = full_ptr[17:1];

	// ----------------------------------------
	// Section split
	// ----------------------------------------
	// Halt section is the top 32 pages in both sizes
	assign in_halt_section = IS_256K ?
		(word_addr >= `BFPD_HALT_START_256K) :
		(word_addr >= `BFPD_HALT_START_128K);

	// ----------------------------------------
	// Boot decode
	// ----------------------------------------
	bfpd_boot_decode #(
		.IS_256K(IS_256K)
	) u_boot (
		.boot_size_select(boot_size_select),
		.boot_start(boot_start),
		.app_end(app_end),
		.boot_words(boot_words)
	);

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Zero wait states; unmapped reads give zero, no error
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_acc = psel & penable & pwrite;
	assign rd_acc = psel & ~penable & ~pwrite;
	assign ctrl_wr = wr_acc & (paddr == `BFPD_OFF_CTRL);
	assign ptr_wr = wr_acc & (paddr == `BFPD_OFF_PTR);
	assign ext_wr = wr_acc & (paddr == `BFPD_OFF_EXT);
	assign busy = (state_q != ST_IDLE);

	// ----------------------------------------
	// Commands
	// ----------------------------------------
	// Commands while busy are dropped: one operation at a time
	assign cmd_fill = ctrl_wr & pwdata[`BFPD_CTRL_FILL] & ~busy;
	assign cmd_erase = ctrl_wr & pwdata[`BFPD_CTRL_ERASE] &
		~busy & ~cmd_fill;
	assign cmd_write = ctrl_wr & pwdata[`BFPD_CTRL_WRITE] &
		~busy & ~cmd_fill & ~cmd_erase;
	// Re-enable only counts once the operation has ended
	assign cmd_reen = ctrl_wr & pwdata[`BFPD_CTRL_REEN] & ~busy;
	assign start_op = cmd_erase | cmd_write;
	assign start_rww = start_op & ~in_halt_section;
	assign clear_busy = cmd_reen | cmd_fill;

	// ----------------------------------------
	// Pointer registers
	// ----------------------------------------
	// Smaller part keeps only one extension bit
	assign ext_d = IS_256K ? pwdata[1:0] :
		{1'b0, pwdata[0]};

	always @(posedge sys_clk)
	begin
		if (srst)
			pointer_q <= 16'h0000;
		else if (ptr_wr)
			pointer_q <= pwdata[15:0];
	end

	always @(posedge sys_clk)
	begin
		if (srst)
			page_extension_register <= 2'h0;
		else if (ext_wr)
			page_extension_register <= ext_d;
	end

	// ----------------------------------------
	// Readback words
	// ----------------------------------------
	assign stat_word = {27'h0000000,
		pointer_byte_select, in_halt_section,
		core_stall, section_busy_flag, busy};
	assign decode_word = {15'h0000, page_index_wide, word_index};
	assign boot_word = {1'b0, boot_words, boot_start};
	assign optime_word = {16'h0000, OP_CYCLES};
	assign app_end_word = {15'h0000, app_end};

	// Unmapped reads give zero rather than an error
	always @*
	begin
		read_data_d = 32'h00000000;
		case (paddr)
			`BFPD_OFF_PTR: read_data_d = {16'h0000, pointer_q};
			`BFPD_OFF_EXT: read_data_d = {30'h00000000, page_extension_register};
			`BFPD_OFF_STAT: read_data_d = stat_word;
			`BFPD_OFF_DECODE: read_data_d = decode_word;
			`BFPD_OFF_BOOT: read_data_d = boot_word;
			`BFPD_OFF_OPTIME: read_data_d = optime_word;
			`BFPD_OFF_APPEND: read_data_d = app_end_word;
			default: read_data_d = 32'h00000000;
		endcase
	end

	// Loaded at setup so data stands for the access phase
	always @(posedge sys_clk)
	begin
		if (srst)
			prdata <= 32'h00000000;
		else if (rd_acc)
			prdata <= read_data_d;
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (cmd_erase)
					state_d = ST_ERASE;
				else if (cmd_write)
					state_d = ST_WRITE;
			end
			ST_ERASE:
			begin
				if (count_q == 16'h0001)
					state_d = ST_IDLE;
			end
			ST_WRITE:
			begin
				if (count_q == 16'h0001)
					state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk)
	begin
		if (srst)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// Loaded at start, counts down to zero
	always @(posedge sys_clk)
	begin
		if (srst)
			count_q <= 16'h0000;
		else if (start_op)
			count_q <= OP_LOAD;
		else if (count_q != 16'h0000)
			count_q <= count_q - 16'h0001;
	end

	always @(posedge sys_clk)
	begin
		if (srst)
			halt_op_q <= 1'b0;
		else if (start_op)
			halt_op_q <= in_halt_section;
	end

	// Word bits are not used; page index alone targets
	always @(posedge sys_clk)
	begin
		if (srst)
			op_page_q <= 10'h000;
		else if (start_op)
			op_page_q <= page_index_wide;
	end

	// ----------------------------------------
	// Section busy and stall
	// ----------------------------------------
	// Set on start beats a same-cycle re-enable
	always @(posedge sys_clk)
	begin
		if (srst)
			section_busy_flag <= 1'b0;
		else if (start_rww)
			section_busy_flag <= 1'b1;
		else if (clear_busy)
			section_busy_flag <= 1'b0;
	end

	assign section_read_block = section_busy_flag;
	// Stall drops in the same cycle as busy
	assign core_stall = busy & halt_op_q;

	// ----------------------------------------
	// Buffer fill
	// ----------------------------------------
	always @(posedge sys_clk)
	begin
		if (srst)
			fill_strobe_q <= 1'b0;
		else
			fill_strobe_q <= cmd_fill;
	end

	// Byte select dropped: stores are whole words
	always @(posedge sys_clk)
	begin
		if (srst)
			fill_word_q <= 7'h00;
		else if (cmd_fill)
			fill_word_q <= word_index;
	end

	// ----------------------------------------
	// Byte select
	// ----------------------------------------
	// Only a program read moves the byte select
	always @(posedge sys_clk)
	begin
		if (srst)
			read_byte_high_q <= 1'b0;
		else if (load_program_read)
			read_byte_high_q <= pointer_byte_select;
	end
endmodule

// File: sim/bfpd_core_model.sv
`timescale 1ns/1ps
// ----
// Core issuing program reads
// ----
module bfpd_core_model
(
	input wire sys_clk,
	input wire core_stall,
	input wire fetch_req,
	output reg load_program_read
);
initial load_program_read = 1'b0;
// Halted core issues nothing
always @(posedge sys_clk)
	load_program_read <= fetch_req && !core_stall;
endmodule

// File: sim/bfpd_top_assertions.sv
`timescale 1ns/1ps
// ----
// Port checks
// ----
module bfpd_chk
#(
	parameter IS_256K = 0
)
(
	input wire sys_clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire load_program_read,
	input wire section_read_block,
	input wire core_stall,
	input wire [9:0] op_page_q,
	input wire [6:0] fill_word_q,
	input wire fill_strobe_q,
	input wire read_byte_high_q
);
localparam [9:0] HALT_PG = IS_256K ? 10'h3E0 : 10'h1E0;
default clocking cb @(posedge sys_clk);
endclocking
default disable iff (srst);
chk_strobe_pulse: assert property (fill_strobe_q |=> !fill_strobe_q)
	else $error("fill strobe too long");
chk_strobe_cause: assert property (fill_strobe_q |->
	$past(psel && penable && pwrite && paddr == 8'h00 && pwdata[0]))
	else $error("fill strobe without fill write");
chk_word_hold: assert property (!fill_strobe_q |-> $stable(fill_word_q))
	else $error("fill word moved");
chk_stall_span: assert property ($rose(core_stall) |->
	core_stall[*3] ##[1:4] !core_stall)
	else $error("stall span wrong");
chk_page_cause: assert property ($changed(op_page_q) |->
	core_stall || section_read_block)
	else $error("page moved without operation");
chk_byte_hold: assert property (!load_program_read |=>
	$stable(read_byte_high_q))
	else $error("byte select moved");
chk_halt_page: assert property ($rose(core_stall) |->
	op_page_q >= HALT_PG)
	else $error("stall below halt section");
chk_rww_page: assert property ($rose(section_read_block) |->
	op_page_q < HALT_PG)
	else $error("block in halt section");
cover property (fill_strobe_q);
cover property ($rose(core_stall));
cover property ($rose(section_read_block));
endmodule
bind bfpd_top bfpd_chk #(.IS_256K(IS_256K)) u_chk(.*);

// File: sim/boot_flash_partition_decoder_test.sv
`timescale 1ns/1ps
module boot_flash_partition_decoder_test;
reg sys_clk = 1'b0;
reg srst = 1'b1;
reg psel = 1'b0;
reg penable = 1'b0;
reg pwrite = 1'b0;
reg [7:0] paddr = 8'h00;
reg [31:0] pwdata = 32'h00000000;
reg [31:0] rd;
reg [31:0] rd_s;
reg [1:0] boot_size_select = 2'h3;
reg fetch_req = 1'b0;
reg [6:0] seen_word = 7'h00;
reg [13:0] bw;
integer fails = 0;
integer cmp_count = 0;
integer i;
wire pready, pslverr, load_program_read, section_read_block, core_stall;
wire fill_strobe_q, read_byte_high_q;
wire [31:0] prdata;
wire [9:0] op_page_q;
wire [6:0] fill_word_q;
wire pready_s, pslverr_s, section_read_block_s, core_stall_s;
wire fill_strobe_s, read_byte_high_s;
wire [31:0] prdata_s;
wire [9:0] op_page_s;
wire [6:0] fill_word_s;
always #12.5 sys_clk = ~sys_clk;
// Short op count keeps the run brief
bfpd_top #(.IS_256K(1), .OP_CYCLES(16'h0004)) u_bfpd_top(.*);
bfpd_top #(.IS_256K(0), .OP_CYCLES(16'h0004)) u_bfpd_top_128k(
	.sys_clk(sys_clk),
	.srst(srst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.pready(pready_s),
	.prdata(prdata_s),
	.pslverr(pslverr_s),
	.boot_size_select(boot_size_select),
	.load_program_read(load_program_read),
	.section_read_block(section_read_block_s),
	.core_stall(core_stall_s),
	.op_page_q(op_page_s),
	.fill_word_q(fill_word_s),
	.fill_strobe_q(fill_strobe_s),
	.read_byte_high_q(read_byte_high_s)
);
bfpd_core_model u_bfpd_core_model(.*);
always @(posedge sys_clk)
	if (fill_strobe_q)
		seen_word <= fill_word_q;
// ----
// Bus and compare tasks
// ----
task chk(input string nm, input [31:0] e, input [31:0] g);
begin
	cmp_count++;
	if (g !== e)
	begin
		fails++;
		$display("mismatch %s expected %h seen %h", nm, e, g);
	end
end
endtask
task xfer(input w, input [7:0] a, input [31:0] d);
begin
	@(posedge sys_clk);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge sys_clk);
	penable <= 1'b1;
	@(posedge sys_clk);
	while (pready !== 1'b1 || pready_s !== 1'b1)
		@(posedge sys_clk);
	rd = prdata;
	rd_s = prdata_s;
	chk("slave error", 32'h0, {30'h0, pslverr, pslverr_s});
	psel <= 1'b0;
	penable <= 1'b0;
end
endtask
task setp(input [1:0] ext, input [15:0] ptr);
begin
	xfer(1'b1, 8'h08, {30'h0, ext});
	xfer(1'b1, 8'h04, {16'h0, ptr});
end
endtask
task give_verdict;
begin
	$display("comparisons %0d mismatches %0d", cmp_count, fails);
	if (fails == 0 && cmp_count > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
end
endtask
initial
begin
	#50000;
	fails++;
	give_verdict;
end
initial
begin
	repeat (6) @(posedge sys_clk);
	srst <= 1'b0;
	for (i = 0; i < 4; i = i + 1)
	begin
		boot_size_select <= i[1:0];
		bw = 14'h1000 >> i;
		xfer(1'b0, 8'h14, 32'h0);
		chk("boot", {1'b0, bw, 17'h1FFFF - {3'h0, bw} + 17'h1}, rd);
		chk("boot 128k", {1'b0, bw, 17'h10000 - {3'h0, bw}}, rd_s);
	end
	xfer(1'b0, 8'h1C, 32'h0);
	chk("app end", 32'h1FDFF, rd);
	chk("app end 128k", 32'h0FDFF, rd_s);
	xfer(1'b0, 8'h18, 32'h0);
	chk("op time", 32'h4, rd);
	setp(2'h3, 16'hFFFE);
	xfer(1'b0, 8'h10, 32'h0);
	chk("decode top", 32'h1FFFF, rd);
	chk("decode top 128k", 32'hFFFF, rd_s);
	setp(2'h2, 16'h0101);
	xfer(1'b0, 8'h10, 32'h0);
	chk("decode odd", 32'h10080, rd);
	chk("decode odd 128k", 32'h80, rd_s);
	fetch_req <= 1'b1;
	@(posedge sys_clk);
	fetch_req <= 1'b0;
	repeat (2) @(posedge sys_clk);
	chk("byte high", 32'h1, {31'h0, read_byte_high_q});
	setp(2'h0, 16'h00AB);
	xfer(1'b1, 8'h00, 32'h1);
	repeat (2) @(posedge sys_clk);
	chk("fill word", 32'h55, {25'h0, seen_word});
	setp(2'h3, 16'hDF00);
	xfer(1'b1, 8'h00, 32'h2);
	@(negedge sys_clk);
	chk("rww block", 32'h1, {31'h0, section_read_block});
	chk("rww stall", 32'h0, {31'h0, core_stall});
	chk("erase page", 32'h3DF, {22'h0, op_page_q});
	chk("rww block 128k", 32'h1, {31'h0, section_read_block_s});
	chk("erase page 128k", 32'h1DF, {22'h0, op_page_s});
	repeat (8) @(posedge sys_clk);
	xfer(1'b1, 8'h00, 32'h8);
	@(negedge sys_clk);
	chk("reenable", 32'h0, {31'h0, section_read_block});
	chk("reenable 128k", 32'h0, {31'h0, section_read_block_s});
	setp(2'h3, 16'hE000);
	xfer(1'b1, 8'h00, 32'h4);
	fetch_req <= 1'b1;
	@(negedge sys_clk);
	chk("halt stall", 32'h1, {31'h0, core_stall});
	chk("write page", 32'h3E0, {22'h0, op_page_q});
	chk("halt stall 128k", 32'h1, {31'h0, core_stall_s});
	chk("write page 128k", 32'h1E0, {22'h0, op_page_s});
	xfer(1'b0, 8'h0C, 32'h0);
	chk("status", 32'h0D, rd);
	chk("status 128k", 32'h0D, rd_s);
	@(negedge sys_clk);
	chk("halted read", 32'h0, {31'h0, load_program_read});
	repeat (6) @(posedge sys_clk);
	fetch_req <= 1'b0;
	chk("stall end", 32'h0, {31'h0, core_stall});
	chk("resumed read", 32'h1, {31'h0, load_program_read});
	xfer(1'b0, 8'h20, 32'h0);
	chk("unmapped", 32'h0, rd);
	give_verdict;
end
endmodule
